// ---- design/force_pkg.sv ----
// Constants and types for the input force override block
package force_pkg;
  localparam int NUM_INPUTS_DEF = 32;
  localparam int NUM_OUTPUTS_DEF = 16;
  localparam int MAX_FORCED_DEF = 10;
  localparam int CLK_HZ = 100_000_000;
  // Power-on availability window
  localparam longint AVAIL_WINDOW_HOURS = 18;
  localparam longint AVAIL_WINDOW_CYCLES = AVAIL_WINDOW_HOURS * 3600 * CLK_HZ;
  // Error timeout
  localparam longint ERR_TIMEOUT_SEC = 3;
  localparam longint ERR_TIMEOUT_CYCLES = ERR_TIMEOUT_SEC * CLK_HZ;
  // Duration units: user duration counted in seconds
  localparam int SEC_CYCLES = CLK_HZ;
  // Indicator flash rate
  localparam int FLASH_HZ = 1;
  localparam int FLASH_HALF_CYCLES = CLK_HZ / (2 * FLASH_HZ);
  localparam int DUR_W = 16;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DURATION = 8'h08;
  localparam logic [7:0] REG_REMAIN = 8'h0c;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_FORCE_EN = 8'h14;
  localparam logic [7:0] REG_FORCE_VAL = 8'h18;
  localparam logic [7:0] REG_PHYS = 8'h1c;
  localparam logic [7:0] REG_DIFF = 8'h20;
  localparam logic [7:0] REG_TARGET = 8'h24;
  localparam logic [7:0] REG_KIND = 8'h28;
  // CTRL bits
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_FORCE_ON = 2;
  localparam int CTRL_FORCE_OFF = 3;
  localparam int CTRL_CLR_VERIFIED = 4;
  localparam int CTRL_SET_VERIFIED = 5;
  localparam int CTRL_HOST_ALIVE = 6;
  localparam int CTRL_HOST_ERROR = 7;
  localparam int CTRL_LOGOUT = 8;
  localparam int CTRL_CFG_XFER = 9;
  // CMD codes (bits 1:0), selected inputs in TARGET
  localparam logic [1:0] CMD_FORCE_HIGH = 2'h0;
  localparam logic [1:0] CMD_FORCE_LOW = 2'h1;
  localparam logic [1:0] CMD_TOGGLE = 2'h2;
  localparam logic [1:0] CMD_RELEASE = 2'h3;
  // STATUS bits
  localparam int ST_RUN = 0;
  localparam int ST_FORCE = 1;
  localparam int ST_VERIFIED = 2;
  localparam int ST_WINDOW = 3;
  localparam int ST_REJECT = 4;
  localparam int ST_FIRST = 5;
  localparam int ST_COUNT_LO = 8;
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,
    ST_RUNNING = 2'b01,
    ST_FORCING = 2'b10
  } dev_state_t;
endpackage

// ---- design/input_force_override.sv ----
// Input force override for a safety controller's logic inputs
// Behaviour
// - Forced value replaces physical input for logic
// - Only logic inputs forceable, never safe outputs
// - Activation only within power-on window
// - Activation refused while configuration verified
// - Accepted request moves stop to forced run
// - Duration timeout ends force; remaining time readable
// - Error ends force after fixed timeout
// - Force end drives outputs low, stops
// - Logout, config transfer, stop refused while forcing
// - At most ten inputs forced at once
// - One forced value seen everywhere in logic
// - Fast shut-off uses physical inputs
// - Gateway image carries physical values only
// - Release resumes physical value
// - Toggle inverts forced value of selection
// - Report forced-differs and physical value
// - Stop-to-run pulses first-cycle, resets timers
//
// The placing of the registers and the plain strobed port are this design's own decisions.
module input_force_override
  import force_pkg::*;
#(
  parameter int NUM_INPUTS = NUM_INPUTS_DEF,
  parameter int NUM_OUTPUTS = NUM_OUTPUTS_DEF,
  parameter int MAX_FORCED = MAX_FORCED_DEF,
  parameter longint AVAIL_CYCLES = AVAIL_WINDOW_CYCLES,
  parameter longint ERR_CYCLES = ERR_TIMEOUT_CYCLES,
  parameter int SEC_DIV = SEC_CYCLES,
  parameter int FLASH_DIV = FLASH_HALF_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [NUM_INPUTS-1:0] I_PHYS_IN,
  input wire logic [NUM_INPUTS-1:0] I_IN_IS_LOGIC,
  input wire logic [NUM_OUTPUTS-1:0] I_LOGIC_OUT,
  input wire logic I_LOGIC_CYCLE,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic [NUM_INPUTS-1:0] O_LOGIC_IN,
  output logic [NUM_INPUTS-1:0] O_FAST_IN,
  output logic [NUM_INPUTS-1:0] O_GATEWAY_IN,
  output logic [NUM_OUTPUTS-1:0] O_GATEWAY_OUT,
  output logic [NUM_OUTPUTS-1:0] O_OUT,
  output logic O_RUN,
  output logic O_OVERRIDE_RUN_STATE,
  output logic O_FIRST_CYCLE,
  output logic O_LOGIC_RESET,
  output logic O_CONFIG_VERIFIED_INDICATOR
);
  localparam int IDX_W = $clog2(NUM_INPUTS);
  localparam int CNT_W = $clog2(MAX_FORCED + 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NUM_INPUTS-1:0] phys_s1;
  logic [NUM_INPUTS-1:0] phys;
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      phys_s1 <= '0;
      phys <= '0;
    end else begin
      phys_s1 <= I_PHYS_IN;
      phys <= phys_s1;
    end
  end

  // ****************************************
  // Device state and control
  // ****************************************
  dev_state_t state;
  logic verified, window_open, reject, err_pending, first_pending;
  logic forcing, end_force, wr_ctrl, wr_cmd, force_req, dur_expired, err_expired;
  logic [63:0] window_cnt, err_cnt;
  logic [DUR_W-1:0] remain, duration;
  logic [31:0] sec_cnt;
  logic [NUM_INPUTS-1:0] force_en, force_val, target;
  logic [CNT_W-1:0] force_count;

  assign forcing = (state == ST_FORCING);
  assign wr_ctrl = I_WR && (I_ADDR == REG_CTRL);
  assign wr_cmd = I_WR && (I_ADDR == REG_CMD);
  assign force_req = wr_ctrl && I_WDATA[CTRL_FORCE_ON];
  assign dur_expired = forcing && (remain == '0);
  assign err_expired = forcing && err_pending && (err_cnt >= ERR_CYCLES - 1);
  // Manual end, duration expiry or error expiry all funnel here
  assign end_force = forcing &&
    ((wr_ctrl && I_WDATA[CTRL_FORCE_OFF]) || dur_expired || err_expired);

  // Window counter stops once closed; only a power cycle (reset) reopens it
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      window_cnt <= '0;
      window_open <= 1'b1;
    end else if (window_open) begin
      if (window_cnt >= AVAIL_CYCLES - 1) begin
        window_open <= 1'b0;
      end else begin
        window_cnt <= window_cnt + 64'h1;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      verified <= 1'b0;
    end else if (wr_ctrl && I_WDATA[CTRL_CLR_VERIFIED]) begin
      verified <= 1'b0;
    end else if (wr_ctrl && I_WDATA[CTRL_SET_VERIFIED] && !forcing) begin
      verified <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state <= ST_STOP;
    end else begin
      unique case (state)
        ST_STOP: begin
          if (force_req && window_open && !verified) begin
            state <= ST_FORCING;
          end else if (wr_ctrl && I_WDATA[CTRL_START]) begin
            state <= ST_RUNNING;
          end
        end
        ST_RUNNING: begin
          if (wr_ctrl && I_WDATA[CTRL_STOP]) begin
            state <= ST_STOP;
          end
        end
        ST_FORCING: begin
          if (end_force) begin
            state <= ST_STOP;
          end
        end
      endcase
    end
  end

  // Sticky refusal flag; cleared by writing CTRL with no request bits
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      reject <= 1'b0;
    end else if (force_req && (state != ST_STOP || !window_open || verified)) begin
      reject <= 1'b1;
    end else if (forcing && wr_ctrl && (I_WDATA[CTRL_STOP] || I_WDATA[CTRL_LOGOUT] ||
                 I_WDATA[CTRL_CFG_XFER])) begin
      reject <= 1'b1;
    end else if (wr_cmd && !forcing) begin
      reject <= 1'b1;
    end else if (wr_ctrl && I_WDATA[9:0] == 10'h000) begin
      reject <= 1'b0;
    end
  end

  // ****************************************
  // Duration and error timers
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      duration <= '0;
    end else if (I_WR && I_ADDR == REG_DURATION && !forcing) begin
      duration <= I_WDATA[DUR_W-1:0];
    end
  end

  // A CMD write restarts the countdown from the chosen duration
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      remain <= '0;
      sec_cnt <= '0;
    end else if (!forcing || wr_cmd) begin
      remain <= (state == ST_STOP && force_req) ? duration : (forcing ? duration : '0);
      sec_cnt <= '0;
    end else if (sec_cnt >= SEC_DIV - 1) begin
      sec_cnt <= '0;
      if (remain != '0) begin
        remain <= remain - 1'b1;
      end
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
    end
  end

  // Error latches on loss of host; a later alive write cancels it
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      err_pending <= 1'b0;
      err_cnt <= '0;
    end else if (!forcing) begin
      err_pending <= 1'b0;
      err_cnt <= '0;
    end else if (wr_ctrl && I_WDATA[CTRL_HOST_ERROR]) begin
      err_pending <= 1'b1;
    end else if (wr_ctrl && I_WDATA[CTRL_HOST_ALIVE]) begin
      err_pending <= 1'b0;
      err_cnt <= '0;
    end else if (err_pending) begin
      err_cnt <= err_cnt + 64'h1;
    end
  end

  // ****************************************
  // Force slots
  // ****************************************
  always_comb begin
    force_count = '0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      force_count = force_count + CNT_W'(force_en[i]);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      target <= '0;
    end else if (I_WR && I_ADDR == REG_TARGET) begin
      target <= I_WDATA[NUM_INPUTS-1:0];
    end
  end

  // Slots fill in index order; requests past the limit are dropped
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      force_en <= '0;
      force_val <= '0;
    end else if (!forcing || end_force) begin
      force_en <= '0;
      force_val <= '0;
    end else if (wr_cmd) begin
      automatic int unsigned cnt = force_count;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (target[i] && I_IN_IS_LOGIC[i]) begin
          unique case (I_WDATA[1:0])
            CMD_FORCE_HIGH, CMD_FORCE_LOW: begin
              if (force_en[i] || cnt < MAX_FORCED) begin
                if (!force_en[i]) begin
                  cnt++;
                end
                force_en[i] <= 1'b1;
                force_val[i] <= (I_WDATA[1:0] == CMD_FORCE_HIGH);
              end
            end
            CMD_TOGGLE: begin
              if (force_en[i]) begin
                force_val[i] <= ~force_val[i];
              end
            end
            CMD_RELEASE: begin
              force_en[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // Outputs to logic, hardware paths, gateway
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_LOGIC_IN <= '0;
      O_FAST_IN <= '0;
      O_GATEWAY_IN <= '0;
      O_GATEWAY_OUT <= '0;
      O_OUT <= '0;
    end else begin
      // One merged vector feeds every page of the logic
      O_LOGIC_IN <= (phys & ~force_en) | (force_val & force_en);
      O_FAST_IN <= phys;
      O_GATEWAY_IN <= phys;
      O_GATEWAY_OUT <= O_OUT;
      O_OUT <= (state == ST_STOP || end_force) ? '0 : I_LOGIC_OUT;
    end
  end

  // First-cycle status held until one logic execution period completes
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      first_pending <= 1'b0;
      O_FIRST_CYCLE <= 1'b0;
      O_LOGIC_RESET <= 1'b0;
    end else begin
      O_LOGIC_RESET <= 1'b0;
      if (state == ST_STOP && (force_req && window_open && !verified ||
          wr_ctrl && I_WDATA[CTRL_START])) begin
        first_pending <= 1'b1;
        O_FIRST_CYCLE <= 1'b1;
        O_LOGIC_RESET <= 1'b1;
      end else if (first_pending && I_LOGIC_CYCLE) begin
        first_pending <= 1'b0;
        O_FIRST_CYCLE <= 1'b0;
      end else if (state == ST_STOP) begin
        first_pending <= 1'b0;
        O_FIRST_CYCLE <= 1'b0;
      end
    end
  end

  // ****************************************
  // Status and indicator
  // ****************************************
  logic [31:0] flash_cnt;
  logic flash;
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      flash_cnt <= '0;
      flash <= 1'b0;
    end else if (flash_cnt >= FLASH_DIV - 1) begin
      flash_cnt <= '0;
      flash <= ~flash;
    end else begin
      flash_cnt <= flash_cnt + 32'h1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RUN <= 1'b0;
      O_OVERRIDE_RUN_STATE <= 1'b0;
      O_CONFIG_VERIFIED_INDICATOR <= 1'b0;
    end else begin
      O_RUN <= (state != ST_STOP) && !end_force;
      O_OVERRIDE_RUN_STATE <= forcing && !end_force;
      O_CONFIG_VERIFIED_INDICATOR <= verified | flash;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RDATA <= '0;
    end else if (I_RD) begin
      unique case (I_ADDR)
        REG_STATUS: begin
          O_RDATA <= '0;
          O_RDATA[ST_RUN] <= state != ST_STOP;
          O_RDATA[ST_FORCE] <= forcing;
          O_RDATA[ST_VERIFIED] <= verified;
          O_RDATA[ST_WINDOW] <= window_open;
          O_RDATA[ST_REJECT] <= reject;
          O_RDATA[ST_FIRST] <= O_FIRST_CYCLE;
          O_RDATA[ST_COUNT_LO +: CNT_W] <= force_count;
        end
        REG_DURATION: O_RDATA <= 32'(duration);
        REG_REMAIN: O_RDATA <= 32'(remain);
        REG_FORCE_EN: O_RDATA <= 32'(force_en);
        REG_FORCE_VAL: O_RDATA <= 32'(force_val);
        REG_PHYS: O_RDATA <= 32'(phys);
        REG_DIFF: O_RDATA <= 32'(force_en & (force_val ^ phys));
        REG_TARGET: O_RDATA <= 32'(target);
        REG_KIND: O_RDATA <= 32'(I_IN_IS_LOGIC);
        default: O_RDATA <= '0;
      endcase
    end else begin
      O_RDATA <= '0;
    end
  end
endmodule

// ---- verification/force_override_props.sv ----
// Assertion checker for the input force override block
module force_override_props #(
  parameter int NUM_INPUTS = 32,
  parameter int NUM_OUTPUTS = 16,
  parameter int FLASH_DIV = 5
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_RD,
  input wire logic I_LOGIC_CYCLE,
  input wire logic [31:0] O_RDATA,
  input wire logic [NUM_INPUTS-1:0] O_LOGIC_IN,
  input wire logic [NUM_INPUTS-1:0] O_FAST_IN,
  input wire logic [NUM_INPUTS-1:0] O_GATEWAY_IN,
  input wire logic [NUM_OUTPUTS-1:0] O_GATEWAY_OUT,
  input wire logic [NUM_OUTPUTS-1:0] O_OUT,
  input wire logic O_RUN,
  input wire logic O_OVERRIDE_RUN_STATE,
  input wire logic O_FIRST_CYCLE,
  input wire logic O_LOGIC_RESET,
  input wire logic O_CONFIG_VERIFIED_INDICATOR
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Helper logic
  // ****
  // Cycles the indicator has stayed low; a long steady high is legal when verified
  int unsigned hold;
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      hold <= 0;
    end else begin
      hold <= O_CONFIG_VERIFIED_INDICATOR ? 0 : hold + 1;
    end
  end
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  // ****
  // Assertions
  // ****
  // Three quiet cycles give slot clearing time to land after force ends
  phys_pass_a: assert property (!O_OVERRIDE_RUN_STATE [*3] |-> O_LOGIC_IN == O_FAST_IN)
    else $error("logic inputs differ from physical outside force mode");
  fast_gw_a: assert property (O_FAST_IN == O_GATEWAY_IN)
    else $error("fast path and gateway image disagree");
  gw_out_a: assert property (O_GATEWAY_OUT == $past(O_OUT))
    else $error("gateway output image not the driven outputs");
  end_low_a: assert property ($fell(O_OVERRIDE_RUN_STATE) |-> ##[0:2] (O_OUT == '0 && !O_RUN))
    else $error("outputs not low or still running after force end");
  run_force_a: assert property (O_OVERRIDE_RUN_STATE |-> O_RUN)
    else $error("force mode without run state");
  rst_pulse_a: assert property (O_LOGIC_RESET |=> !O_LOGIC_RESET)
    else $error("timer reset pulse longer than one cycle");
  first_set_a: assert property (O_LOGIC_RESET |-> ##[0:1] O_FIRST_CYCLE)
    else $error("first cycle flag missing at start");
  first_end_a: assert property (O_FIRST_CYCLE && I_LOGIC_CYCLE && !O_LOGIC_RESET |-> ##[1:2] !O_FIRST_CYCLE)
    else $error("first cycle flag outlives the logic period");
  rd_idle_a: assert property (!$past(I_RD) |-> O_RDATA == '0)
    else $error("read data present without a read");
  flash_a: assert property (!O_CONFIG_VERIFIED_INDICATOR |-> hold <= FLASH_DIV + 1)
    else $error("indicator stuck low instead of flashing");
  force_on_c: cover property ($rose(O_OVERRIDE_RUN_STATE));
  force_off_c: cover property ($fell(O_OVERRIDE_RUN_STATE));
  start_c: cover property (O_LOGIC_RESET);
endmodule

bind input_force_override force_override_props #(
  .NUM_INPUTS(NUM_INPUTS), .NUM_OUTPUTS(NUM_OUTPUTS), .FLASH_DIV(FLASH_DIV)
) u_props (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_RD(I_RD), .I_LOGIC_CYCLE(I_LOGIC_CYCLE),
  .O_RDATA(O_RDATA), .O_LOGIC_IN(O_LOGIC_IN), .O_FAST_IN(O_FAST_IN),
  .O_GATEWAY_IN(O_GATEWAY_IN), .O_GATEWAY_OUT(O_GATEWAY_OUT), .O_OUT(O_OUT), .O_RUN(O_RUN),
  .O_OVERRIDE_RUN_STATE(O_OVERRIDE_RUN_STATE), .O_FIRST_CYCLE(O_FIRST_CYCLE),
  .O_LOGIC_RESET(O_LOGIC_RESET), .O_CONFIG_VERIFIED_INDICATOR(O_CONFIG_VERIFIED_INDICATOR)
);

// ---- verification/logic_prog_model.sv ----
// Model of the logic program that consumes the block's logic inputs
module logic_prog_model #(
  parameter int NUM_INPUTS = 32,
  parameter int NUM_OUTPUTS = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [NUM_INPUTS-1:0] i_logic_in,
  output logic [NUM_OUTPUTS-1:0] o_logic_out,
  output logic o_cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  // Every output follows one input, so a forced value shows wherever it is used
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_logic_out <= '0;
    end else begin
      o_logic_out <= i_logic_in[NUM_OUTPUTS-1:0];
    end
  end
  // A logic period ends every fourth clock
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      phase <= 2'h0;
      o_cycle <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      o_cycle <= (phase == 2'h3);
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench for the input force override block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import force_pkg::*;
  // ****
  // Signals and instances
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] phys = 32'h8000_0004;
  logic [31:0] is_logic = 32'h7fff_ffff;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] lout, gw_out, outs;
  logic [31:0] rdata, logic_in, fast_in, gw_in;
  logic lcyc, run, ovr, first, lreset, ind;
  int n_mismatch = 0;
  int checks = 0;
  always #5 clk = ~clk;
  // Short counts keep the window and timeouts within a brief run
  input_force_override #(.AVAIL_CYCLES(200), .ERR_CYCLES(30), .SEC_DIV(10), .FLASH_DIV(5)) u_dut (
    .I_CLK(clk), .I_RESET(rst), .I_PHYS_IN(phys), .I_IN_IS_LOGIC(is_logic),
    .I_LOGIC_OUT(lout), .I_LOGIC_CYCLE(lcyc), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .O_LOGIC_IN(logic_in), .O_FAST_IN(fast_in),
    .O_GATEWAY_IN(gw_in), .O_GATEWAY_OUT(gw_out), .O_OUT(outs), .O_RUN(run),
    .O_OVERRIDE_RUN_STATE(ovr), .O_FIRST_CYCLE(first), .O_LOGIC_RESET(lreset),
    .O_CONFIG_VERIFIED_INDICATOR(ind));
  logic_prog_model u_prog (.i_clk(clk), .i_reset(rst), .i_logic_in(logic_in),
    .o_logic_out(lout), .o_cycle(lcyc));
  // ****
  // Bus and check tasks
  // ****
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(string s, logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(s, rdata & m, e);
  endtask
  task automatic cmd(logic [31:0] tgt, logic [1:0] c);
    wr_reg(REG_TARGET, tgt);
    wr_reg(REG_CMD, {30'h0, c});
    wait_cyc(6);
  endtask
  // Cycles until force mode drops, bounded
  task automatic wait_end(output int n);
    n = 0;
    while (ovr === 1'b1 && n < 400) begin
      wait_cyc(1);
      n++;
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(3);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_verified;
    wr_reg(REG_CTRL, 32'h20);
    wr_reg(REG_CTRL, 32'h4);
    chk_reg("status", REG_STATUS, 32'h1c);
    wait_cyc(12);
    chk("indicator", {31'h0, ind}, 32'h1);
    wr_reg(REG_CTRL, 32'h10);
    wr_reg(REG_CTRL, 32'h0);
    chk_reg("status", REG_STATUS, 32'h8);
  endtask
  task automatic t_start;
    wr_reg(REG_DURATION, 32'd20);
    wr_reg(REG_CTRL, 32'h4);
    wait_cyc(2);
    chk("run", {30'h0, run, ovr}, 32'h3);
    chk_reg("remain", REG_REMAIN, 32'd20);
  endtask
  task automatic t_force;
    cmd(32'h8000_0003, CMD_FORCE_HIGH);
    chk("logic_in", logic_in, 32'h8000_0007);
    chk("fast_in", fast_in, 32'h8000_0004);
    chk("gw_in", gw_in, 32'h8000_0004);
    chk("out", {16'h0, outs}, 32'h7);
    chk("gw_out", {16'h0, gw_out}, 32'h7);
    chk_reg("force_en", REG_FORCE_EN, 32'h3);
    chk_reg("diff", REG_DIFF, 32'h3);
    chk_reg("phys", REG_PHYS, 32'h8000_0004);
    cmd(32'h3, CMD_TOGGLE);
    chk("toggled", logic_in, 32'h8000_0004);
    cmd(32'h5, CMD_RELEASE);
    chk_reg("force_en", REG_FORCE_EN, 32'h2);
    cmd(32'h4, CMD_FORCE_LOW);
    chk("low", logic_in, 32'h8000_0000);
  endtask
  task automatic t_refuse;
    logic [31:0] codes[3] = '{32'h2, 32'h100, 32'h200};
    foreach (codes[i]) begin
      wr_reg(REG_CTRL, codes[i]);
      chk_reg("refused", REG_STATUS, 32'h13, 32'h13);
      wr_reg(REG_CTRL, 32'h0);
    end
  endtask
  task automatic t_limit;
    cmd(32'hfff, CMD_FORCE_HIGH);
    chk_reg("force_en", REG_FORCE_EN, 32'h3ff);
    chk_reg("count", REG_STATUS, 32'ha00, 32'hff00);
    chk("logic_in", logic_in, 32'h8000_03ff);
  endtask
  task automatic t_duration;
    int n;
    wr_reg(REG_CMD, {30'h0, CMD_FORCE_HIGH});
    wait_end(n);
    chk("duration", {31'h0, n inside {[190:215]}}, 32'h1);
    chk("stopped", {15'h0, run, outs}, 32'h0);
    chk_reg("slots", REG_FORCE_EN, 32'h0);
    chk("released", logic_in, 32'h8000_0004);
  endtask
  task automatic t_error;
    int n;
    do_reset;
    wr_reg(REG_DURATION, 32'd50);
    wr_reg(REG_CTRL, 32'h4);
    wr_reg(REG_CTRL, 32'h80);
    wait_end(n);
    chk("err_time", {31'h0, n inside {[26:36]}}, 32'h1);
    chk("stopped", {15'h0, run, outs}, 32'h0);
  endtask
  task automatic t_manual;
    int n;
    wr_reg(REG_CTRL, 32'h1);
    wr_reg(REG_CTRL, 32'h4);
    chk_reg("busy", REG_STATUS, 32'h11, 32'h13);
    wr_reg(REG_CTRL, 32'h2);
    wr_reg(REG_CTRL, 32'h4);
    wr_reg(REG_CTRL, 32'h80);
    wr_reg(REG_CTRL, 32'h40);
    wait_cyc(40);
    chk("alive", {31'h0, ovr}, 32'h1);
    wr_reg(REG_CTRL, 32'h8);
    wait_end(n);
    chk("manual", {31'h0, n < 4}, 32'h1);
    chk("stopped", {15'h0, run, outs}, 32'h0);
  endtask
  task automatic t_window;
    do_reset;
    wait_cyc(210);
    wr_reg(REG_CTRL, 32'h4);
    chk_reg("late", REG_STATUS, 32'h10);
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_cyc(3);
    t_verified;
    t_start;
    t_force;
    t_refuse;
    t_limit;
    t_duration;
    t_error;
    t_manual;
    t_window;
    results();
  end
  // The sequence needs about 650 cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    results();
  end
endmodule
